// file: hw/sss_pkg.sv
`default_nettype none

package sss_pkg;

    // Clock rate and timing figures
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned FP_MASK_NS       = 2000;
    localparam int unsigned NP_MASK_US       = 150;
    localparam int unsigned FP_MASK_CYC      = (FP_MASK_NS * CLK_MHZ) / 1000;
    localparam int unsigned NP_MASK_CYC      = NP_MASK_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 16;

    // Flash guard window around the delay-done instant
    localparam int unsigned FLASH_GUARD_CYC  = 4;

    // Reset values
    localparam logic        SUP_EN_RST       = 1'b1;
    localparam logic        FLAG_RST         = 1'b0;

    typedef enum logic [1:0] {
        SSS_OFF,
        SSS_SETTLE,
        SSS_ARMED
    } sss_state_t;

endpackage : sss_pkg

`default_nettype wire

// file: hw/sss_side.sv
`timescale 1ns/1ps
`default_nettype none

module sss_side #(
    parameter int unsigned NP_CYC = sss_pkg::NP_MASK_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic full_perf,
    input  wire logic deep_lp,
    input  wire logic keep_on_in_low_power,
    input  wire logic restart,
    input  wire logic no_mask,
    input  wire logic trip_sync,
    output logic      comp_on,
    output logic      armed,
    output logic      settle_done,
    output logic      near_done,
    output logic      trip_event
);

    typedef struct packed {
        sss_pkg::sss_state_t          st;
        logic [sss_pkg::CNT_W-1:0]    cnt;
        logic                         on;
        logic                         done;
        logic                         trip;
    } sss_side_state_t;

    sss_side_state_t s_reg;
    sss_side_state_t s_next;
    logic            want_on;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        s_next.trip = 1'b0;
        want_on = enable && !(deep_lp && !keep_on_in_low_power);
        s_next.on = want_on;
        case (s_reg.st)
            sss_pkg::SSS_OFF:
            begin
                if (want_on)
                begin
                    if (no_mask)
                    begin
                        s_next.st = sss_pkg::SSS_ARMED;
                    end
                    else
                    begin
                        s_next.st = sss_pkg::SSS_SETTLE;
                        s_next.cnt = full_perf ? sss_pkg::CNT_W'(sss_pkg::FP_MASK_CYC)
                                               : sss_pkg::CNT_W'(NP_CYC);
                    end
                end
            end
            sss_pkg::SSS_SETTLE:
            begin
                if (!want_on)
                begin
                    s_next.st = sss_pkg::SSS_OFF;
                end
                else if (s_reg.cnt <= sss_pkg::CNT_W'(1))
                begin
                    s_next.st   = sss_pkg::SSS_ARMED;
                    s_next.cnt  = '0;
                    s_next.done = 1'b1;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt - sss_pkg::CNT_W'(1);
                end
            end
            sss_pkg::SSS_ARMED:
            begin
                if (!want_on)
                begin
                    s_next.st = sss_pkg::SSS_OFF;
                end
                else
                begin
                    s_next.trip = trip_sync;
                end
            end
            default:
            begin
                s_next.st = sss_pkg::SSS_OFF;
            end
        endcase
        // clear with want_on arms at once, no mask; otherwise restart goes to off
        if (restart)
        begin
            s_next.st = (no_mask && want_on) ? sss_pkg::SSS_ARMED : sss_pkg::SSS_OFF;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign comp_on     = s_reg.on;
    assign armed       = (s_reg.st == sss_pkg::SSS_ARMED);
    assign settle_done = s_reg.done;
    assign trip_event  = s_reg.trip;
    assign near_done   = (s_reg.st == sss_pkg::SSS_SETTLE)
                         && (s_reg.cnt <= sss_pkg::CNT_W'(sss_pkg::FLASH_GUARD_CYC));

endmodule : sss_side

`default_nettype wire

// file: hw/sss_top.sv
`timescale 1ns/1ps
`default_nettype none

module sss_top #(
    parameter int unsigned NP_CYC = sss_pkg::NP_MASK_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic power_up_clear_reset,
    input  wire logic deep_low_power_modes,
    input  wire logic hi_enable,
    input  wire logic hi_full_performance,
    input  wire logic hi_keep_on_in_low_power,
    input  wire logic hi_reset_enable,
    input  wire logic hi_ctrl_write,
    input  wire logic lo_enable,
    input  wire logic lo_full_performance,
    input  wire logic lo_keep_on_in_low_power,
    input  wire logic lo_reset_enable,
    input  wire logic lo_ctrl_write,
    input  wire logic hi_trip_pin,
    input  wire logic lo_trip_pin,
    input  wire logic hi_flag_clear,
    input  wire logic lo_flag_clear,
    input  wire logic hi_delay_clear,
    input  wire logic lo_delay_clear,
    input  wire logic core_level_change,
    output logic      hi_comp_on,
    output logic      lo_comp_on,
    output logic      hi_trip_flag,
    output logic      lo_trip_flag,
    output logic      hi_delay_done_flag,
    output logic      lo_delay_done_flag,
    output logic      por_request,
    output logic      gpio_hiz,
    output logic      flash_hold
);

    typedef struct packed {
        logic [1:0] hi_sync;
        logic [1:0] lo_sync;
        logic       hi_flag;
        logic       lo_flag;
        logic       hi_dly;
        logic       lo_dly;
        logic       hi_live;
        logic       lo_live;
        logic       hi_was_off;
        logic       lo_was_off;
        logic       por;
        logic       hiz;
        logic       hold;
        logic       hi_on;
        logic       lo_on;
    } sss_top_state_t;

    sss_top_state_t s_reg;
    sss_top_state_t s_next;

    logic hi_armed;
    logic lo_armed;
    logic hi_done;
    logic lo_done;
    logic lo_near;
    logic hi_ev;
    logic lo_ev;
    logic hi_on_w;
    logic lo_on_w;
    logic hi_en_eff;
    logic lo_en_eff;

    ////////////////////////////////////////////////////////////////////////
    // reset forces both enabled
    assign hi_en_eff = hi_enable | (power_up_clear_reset & sss_pkg::SUP_EN_RST);
    assign lo_en_eff = lo_enable | (power_up_clear_reset & sss_pkg::SUP_EN_RST);

    sss_side #(
        .NP_CYC               (NP_CYC)
    ) u_hi (
        .clock                (clock),
        .rst                  (rst),
        .enable               (hi_en_eff),
        .full_perf            (hi_full_performance),
        .deep_lp              (deep_low_power_modes),
        .keep_on_in_low_power (hi_keep_on_in_low_power),
        .restart              (power_up_clear_reset),
        .no_mask              (power_up_clear_reset),
        .trip_sync            (s_reg.hi_sync[1]),
        .comp_on              (hi_on_w),
        .armed                (hi_armed),
        .settle_done          (hi_done),
        .near_done            (),
        .trip_event           (hi_ev)
    );

    sss_side #(
        .NP_CYC               (NP_CYC)
    ) u_lo (
        .clock                (clock),
        .rst                  (rst),
        .enable               (lo_en_eff),
        .full_perf            (lo_full_performance),
        .deep_lp              (deep_low_power_modes),
        .keep_on_in_low_power (lo_keep_on_in_low_power),
        .restart              (power_up_clear_reset | core_level_change),
        .no_mask              (power_up_clear_reset),
        .trip_sync            (s_reg.lo_sync[1]),
        .comp_on              (lo_on_w),
        .armed                (lo_armed),
        .settle_done          (lo_done),
        .near_done            (lo_near),
        .trip_event           (lo_ev)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next         = s_reg;
        // Trip pins are analog, so two stages first
        s_next.hi_sync = {s_reg.hi_sync[0], hi_trip_pin};
        s_next.lo_sync = {s_reg.lo_sync[0], lo_trip_pin};
        s_next.hi_on   = hi_on_w;
        s_next.lo_on   = lo_on_w;

        if (!power_up_clear_reset)
        begin
            s_next.hi_was_off = !hi_enable;
            s_next.lo_was_off = !lo_enable;
        end
        if (power_up_clear_reset)
        begin
            s_next.hi_live = !s_reg.hi_was_off;
            s_next.lo_live = !s_reg.lo_was_off;
        end
        if (hi_ctrl_write)
        begin
            s_next.hi_live = 1'b1;
        end
        if (lo_ctrl_write)
        begin
            s_next.lo_live = 1'b1;
        end

        if (hi_flag_clear)
        begin
            s_next.hi_flag = 1'b0;
        end
        if (hi_ev && s_reg.hi_live)
        begin
            s_next.hi_flag = 1'b1;
        end
        if (lo_flag_clear)
        begin
            s_next.lo_flag = 1'b0;
        end
        if (lo_ev && s_reg.lo_live)
        begin
            s_next.lo_flag = 1'b1;
        end

        if (hi_delay_clear)
        begin
            s_next.hi_dly = 1'b0;
        end
        if (hi_done && s_reg.hi_live)
        begin
            s_next.hi_dly = 1'b1;
        end
        if (lo_delay_clear)
        begin
            s_next.lo_dly = 1'b0;
        end
        if (lo_done && s_reg.lo_live)
        begin
            s_next.lo_dly = 1'b1;
        end

        s_next.por = (hi_ev && s_reg.hi_live && hi_reset_enable)
                     || (lo_ev && s_reg.lo_live && lo_reset_enable);

        s_next.hiz = (s_next.hi_flag && !hi_armed) || (s_next.lo_flag && !lo_armed)
                     || (s_next.hi_flag && s_reg.hi_sync[1])
                     || (s_next.lo_flag && s_reg.lo_sync[1]);

        s_next.hold = lo_near || lo_done;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_reg         <= '0;
            s_reg.hi_live <= 1'b1;
            s_reg.lo_live <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign hi_comp_on         = s_reg.hi_on;
    assign lo_comp_on         = s_reg.lo_on;
    assign hi_trip_flag       = s_reg.hi_flag;
    assign lo_trip_flag       = s_reg.lo_flag;
    assign hi_delay_done_flag = s_reg.hi_dly;
    assign lo_delay_done_flag = s_reg.lo_dly;
    assign por_request        = s_reg.por;
    assign gpio_hiz           = s_reg.hiz;
    assign flash_hold         = s_reg.hold;

endmodule : sss_top

`default_nettype wire

// file: testbench/sss_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module sss_comp_model (
    input  wire logic clock,
    input  wire logic comp_on,
    input  wire logic sag,
    output logic      trip_pin
);
    initial trip_pin = 1'b0;
    // Unpowered output wanders; the design must ignore it
    always @(posedge clock)
    begin
        trip_pin <= comp_on ? sag : ~trip_pin;
    end
endmodule : sss_comp_model
`default_nettype wire

// file: testbench/sss_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sss_top_monitor #(
    parameter int unsigned NP_CYC = sss_pkg::NP_MASK_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic power_up_clear_reset,
    input wire logic deep_low_power_modes,
    input wire logic lo_enable,
    input wire logic lo_keep_on_in_low_power,
    input wire logic hi_flag_clear,
    input wire logic lo_flag_clear,
    input wire logic lo_delay_clear,
    input wire logic lo_ctrl_write,
    input wire logic core_level_change,
    input wire logic hi_comp_on,
    input wire logic lo_comp_on,
    input wire logic hi_trip_flag,
    input wire logic lo_trip_flag,
    input wire logic lo_delay_done_flag,
    input wire logic por_request,
    input wire logic gpio_hiz,
    input wire logic flash_hold
);
    // Shorter of the two masks; sim shrinks the normal one
    localparam int unsigned MIN_SET = (NP_CYC < sss_pkg::FP_MASK_CYC) ? NP_CYC : sss_pkg::FP_MASK_CYC;
    logic [15:0] on_cnt_reg;
    logic [15:0] on_cnt_next;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    always_comb on_cnt_next = !lo_comp_on ? 16'h0000 : (&on_cnt_reg ? on_cnt_reg : on_cnt_reg + 16'h0001);
    always_ff @(posedge clock or posedge rst) on_cnt_reg <= rst ? 16'h0000 : on_cnt_next;
    ////////////////////////////////////////////////////////////////
    a_lo_flag_sticky: assert property (lo_trip_flag && !lo_flag_clear && !power_up_clear_reset |=> lo_trip_flag)
        else $error("lo trip flag dropped");
    a_hi_flag_sticky: assert property (hi_trip_flag && !hi_flag_clear && !power_up_clear_reset |=> hi_trip_flag)
        else $error("hi trip flag dropped");
    a_lo_dly_sticky: assert property (lo_delay_done_flag && !(lo_delay_clear || core_level_change ||
        power_up_clear_reset || lo_ctrl_write) |=> lo_delay_done_flag) else $error("delay flag dropped");
    a_por_from_trip: assert property (por_request |-> ##[0:1] (hi_trip_flag || lo_trip_flag))
        else $error("reset request without trip");
    a_hiz_needs_flag: assert property (gpio_hiz |-> hi_trip_flag || lo_trip_flag || $past(hi_trip_flag)
        || $past(lo_trip_flag)) else $error("pins floated without flag");
    a_deep_turns_off: assert property ((deep_low_power_modes && !lo_keep_on_in_low_power
        && !power_up_clear_reset) [*3] |-> !lo_comp_on) else $error("comparator kept on in deep mode");
    a_wake_restores: assert property ($fell(deep_low_power_modes) && lo_enable |-> ##[1:3] lo_comp_on)
        else $error("comparator not back on after wake");
    a_mask_length: assert property ($rose(lo_delay_done_flag) |-> on_cnt_reg >= 16'(MIN_SET - 2))
        else $error("settle delay too short");
    a_flash_guard: assert property ($rose(lo_delay_done_flag) |-> $past(flash_hold))
        else $error("flash not held at delay expiry");
    a_puc_enables: assert property (power_up_clear_reset && !deep_low_power_modes
        |-> ##[1:3] (hi_comp_on && lo_comp_on)) else $error("clear did not enable supervisors");
    c_lo_trip: cover property ($rose(lo_trip_flag));
    c_por: cover property ($rose(por_request));
    c_guard: cover property ($rose(flash_hold));
endmodule : sss_top_monitor
bind sss_top sss_top_monitor #(.NP_CYC(NP_CYC)) u_mon (.clock, .rst, .power_up_clear_reset,
    .deep_low_power_modes, .lo_enable, .lo_keep_on_in_low_power, .hi_flag_clear, .lo_flag_clear,
    .lo_delay_clear, .lo_ctrl_write, .core_level_change, .hi_comp_on, .lo_comp_on, .hi_trip_flag,
    .lo_trip_flag, .lo_delay_done_flag, .por_request, .gpio_hiz, .flash_hold);
`default_nettype wire

// file: testbench/sss_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sss_top_tb_top;
    localparam int NP = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic power_up_clear_reset, deep_low_power_modes, core_level_change, hi_sag, lo_sag;
    logic hi_enable, hi_full_performance, hi_keep_on_in_low_power, hi_reset_enable, hi_ctrl_write;
    logic lo_enable, lo_full_performance, lo_keep_on_in_low_power, lo_reset_enable, lo_ctrl_write;
    logic hi_trip_pin, lo_trip_pin, hi_flag_clear, lo_flag_clear, hi_delay_clear, lo_delay_clear;
    logic hi_comp_on, lo_comp_on, hi_trip_flag, lo_trip_flag, hi_delay_done_flag, lo_delay_done_flag;
    logic por_request, gpio_hiz, flash_hold;
    logic [8:0] outs;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    assign outs = {flash_hold, gpio_hiz, por_request, lo_delay_done_flag, hi_delay_done_flag,
        lo_trip_flag, hi_trip_flag, lo_comp_on, hi_comp_on};
    sss_top #(.NP_CYC(NP)) dut (.clock, .rst, .power_up_clear_reset, .deep_low_power_modes,
        .hi_enable, .hi_full_performance, .hi_keep_on_in_low_power, .hi_reset_enable, .hi_ctrl_write,
        .lo_enable, .lo_full_performance, .lo_keep_on_in_low_power, .lo_reset_enable, .lo_ctrl_write,
        .hi_trip_pin, .lo_trip_pin, .hi_flag_clear, .lo_flag_clear, .hi_delay_clear, .lo_delay_clear,
        .core_level_change, .hi_comp_on, .lo_comp_on, .hi_trip_flag, .lo_trip_flag, .hi_delay_done_flag,
        .lo_delay_done_flag, .por_request, .gpio_hiz, .flash_hold);
    sss_comp_model hi_cmp (.clock, .comp_on(hi_comp_on), .sag(hi_sag), .trip_pin(hi_trip_pin));
    sss_comp_model lo_cmp (.clock, .comp_on(lo_comp_on), .sag(lo_sag), .trip_pin(lo_trip_pin));
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Hang guard; whole run needs well under 2000 cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic check(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task automatic seen(input string what, input int b, input int lim);
        for (int n = 0; n < lim && outs[b] !== 1'b1; n++)
            step(1);
        check(what, 1'b1, outs[b]);
    endtask : seen
    ////////////////////////////////////////////////////////////////
    task automatic t_settle;
        check("outputs after reset", 1'b0, |outs);
        lo_enable = 1'b1;
        step(NP - 4);
        check("lo delay early", 1'b0, lo_delay_done_flag);
        check("lo comp on", 1'b1, lo_comp_on);
        seen("flash hold", 8, 8);
        seen("lo delay flag", 5, 10);
        step(3);
        check("lo delay kept", 1'b1, lo_delay_done_flag);
        check("flash released", 1'b0, flash_hold);
        lo_delay_clear = 1'b1;
        step(1);
        lo_delay_clear = 1'b0;
        core_level_change = 1'b1;
        step(1);
        core_level_change = 1'b0;
        check("lo delay cleared", 1'b0, lo_delay_done_flag);
        seen("lo delay relevel", 5, NP + 6);
    endtask : t_settle
    task automatic t_trip;
        {hi_reset_enable, hi_full_performance, hi_enable, hi_sag} = 4'hF;
        step(sss_pkg::FP_MASK_CYC - 10);
        check("hi flag in mask", 1'b0, hi_trip_flag);
        seen("hi trip flag", 2, 30);
        seen("por request", 6, 3);
        seen("gpio float", 7, 3);
        hi_sag = 1'b0;
        step(6);
        check("hi flag kept", 1'b1, hi_trip_flag);
        hi_flag_clear = 1'b1;
        step(1);
        hi_flag_clear = 1'b0;
        step(3);
        check("hi flag cleared", 1'b0, hi_trip_flag);
        check("gpio driven", 1'b0, gpio_hiz);
        check("hi delay done", 1'b1, hi_delay_done_flag);
        hi_delay_clear = 1'b1;
        step(1);
        hi_delay_clear = 1'b0;
        check("hi delay cleared", 1'b0, hi_delay_done_flag);
        lo_sag = 1'b1;
        seen("lo trip flag", 3, 8);
        check("no por lo", 1'b0, por_request);
        lo_sag = 1'b0;
        // Let the trip drain through the synchroniser; set wins over clear
        step(6);
        lo_flag_clear = 1'b1;
        step(1);
        lo_flag_clear = 1'b0;
        check("lo flag cleared", 1'b0, lo_trip_flag);
    endtask : t_trip
    task automatic t_deep;
        hi_keep_on_in_low_power = 1'b1;
        deep_low_power_modes = 1'b1;
        step(5);
        check("lo off deep", 1'b0, lo_comp_on);
        check("hi kept on", 1'b1, hi_comp_on);
        check("no trip when off", 1'b0, lo_trip_flag);
        deep_low_power_modes = 1'b0;
        seen("lo back on", 1, 4);
    endtask : t_deep
    task automatic t_puc;
        lo_enable = 1'b0;
        step(4);
        power_up_clear_reset = 1'b1;
        step(1);
        power_up_clear_reset = 1'b0;
        seen("puc lo on", 1, 4);
        lo_enable = 1'b1;
        step(NP + 10);
        lo_sag = 1'b1;
        step(12);
        check("lo flag dead", 1'b0, lo_trip_flag);
        lo_ctrl_write = 1'b1;
        step(1);
        lo_ctrl_write = 1'b0;
        seen("lo flag revived", 3, NP + 12);
        lo_sag = 1'b0;
    endtask : t_puc
    initial
    begin
        {power_up_clear_reset, deep_low_power_modes, core_level_change, hi_sag, lo_sag, hi_enable,
            hi_full_performance, hi_keep_on_in_low_power, hi_reset_enable, hi_ctrl_write, lo_enable,
            lo_full_performance, lo_keep_on_in_low_power, lo_reset_enable, lo_ctrl_write, hi_flag_clear,
            lo_flag_clear, hi_delay_clear, lo_delay_clear} = '0;
        step(8);
        rst = 1'b0;
        step(1);
        t_settle();
        t_trip();
        t_deep();
        t_puc();
        give_verdict();
    end
endmodule : sss_top_tb_top
`default_nettype wire
